// ===== design/prst_consts.svh
// Constants for the position reset and status tracker.
// Assumes inclusion by bare name from design files.
`ifndef PRST_CONSTS_SVH
`define PRST_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PRST_A_CTRL       4'h0
`define PRST_A_SET_STEPS  4'h1
`define PRST_A_SET_FRAC   4'h2
`define PRST_A_SET_SEC    4'h3
`define PRST_A_STAT_STEPS 4'h4
`define PRST_A_STAT_FRAC  4'h5
`define PRST_A_STAT_SEC   4'h6
`define PRST_A_STAT_SPEED 4'h7
`define PRST_A_STAT_STATE 4'h8
`define PRST_A_STAT_FLAGS 4'h9
`define PRST_A_STAT_TEL0  4'hA
`define PRST_A_STAT_TEL1  4'hB
`define PRST_A_STAT_TEL2  4'hC
`define PRST_A_STAT_DIG   4'hD
`define PRST_A_TARGET     4'hE
// ----------------------------------------
// Control register bits
// ----------------------------------------
`define PRST_C_ZERO       0
`define PRST_C_SETPOS     1
`define PRST_C_IGN_MOTOR  2
`define PRST_C_IGN_ENC    3
`define PRST_C_QUERY      4
`define PRST_C_STOP       5
// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define PRST_CMD_UNKNOWN  4'h0
`define PRST_FRAC_ZERO    8'h00
`define PRST_POS_ZERO     32'h0000_0000
`define PRST_EXT_SUPPLY   1'b1
`endif

// ===== design/prst_pkg.sv
// Types of the position reset and status tracker.
// Assumes prst_consts.svh supplies numeric constants.
package prst_pkg;
    typedef enum logic [1:0] {PRST_PWR_OFF, PRST_PWR_REDUCED, PRST_PWR_NOMINAL,
                              PRST_PWR_LOW_VOLT} prst_pwr_e;
    typedef enum logic [2:0] {PRST_ENC_ABSENT, PRST_ENC_UNKNOWN, PRST_ENC_OK,
                              PRST_ENC_REVERSED, PRST_ENC_FAULTY} prst_enc_e;
    typedef enum logic [1:0] {PRST_WND_OPEN, PRST_WND_OK, PRST_WND_SHORT,
                              PRST_WND_UNKNOWN} prst_wnd_e;
    typedef enum logic [1:0] {PRST_MODE_OPEN, PRST_MODE_LEAD_ENC,
                              PRST_MODE_FEEDBACK, PRST_MODE_DC} prst_mode_e;
    typedef struct packed {
        logic [31:0] steps;
        logic [7:0] frac;
        logic [31:0] enc;
        logic [31:0] target;
        logic [31:0] shift_dest;
        logic [3:0] cmd_code;
        logic cmd_running;
        logic cmd_ok;
        logic [2:0] proto_err;
        logic swap_err;
        logic desync_err;
        logic [31:0] snap_pos;
        logic [7:0] snap_frac;
        logic [31:0] snap_sec;
        logic [31:0] snap_speed;
        logic [31:0] snap_state;
        logic [31:0] snap_flags;
        logic [31:0] snap_tel0;
        logic [31:0] snap_tel1;
        logic [31:0] snap_tel2;
        logic [31:0] snap_dig;
        logic [31:0] set_steps;
        logic [7:0] set_frac;
        logic [31:0] set_enc;
        logic [31:0] rdata;
    } prst_state_s;
endpackage

// ===== design/prst_tracker.sv
// Position counters and status snapshot of a motion controller.
// Assumes motion profile logic supplies step moves, flags and telemetry,
// and that a host bridge drives the plain register port.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ns
`include "prst_consts.svh"
// Behaviour
// - Zero command clears step, microstep and encoder counters.
// - All counters clear in one and the same update.
// - Zero during move keeps move, shifts target by removed position.
// - Pending relative shift keeps its physical destination on zero.
// - Set-position loads step, microstep, encoder; ignore flags skip fields.
// - Set-position keeps stored target physically; move ends same place.
// - Status query returns full record of position, flags, telemetry.
// - Motion state: moving, target speed reached, backlash compensation.
// - Command state: code, running bit, success bit once completed.
// - Command fails when limit stop or alarm stops the move.
// - After reset command reads unknown with successful result.
// - Winding power encodes off, reduced, nominal, low supply.
// - Encoder state five codes; faulty or reversed after statistics.
// - Two windings reported separately: open, ok, short, unknown.
// - Primary holds steps/microsteps; leading encoder, feedback and DC give encoder counts, fraction 0.
// - Secondary holds encoder, steps with leading encoder or feedback, zero for DC.
// - Telemetry reports mA, tens of mV and tenths of degree.
// - Protocol error flags sticky until stop command.
// - Critical flags self clear; swapped limit switch flag sticks.
// - Desync flag sticky, clears only with position correction.
// - Stage memory presence flag, external supply flag always set.
// - Digital flags after inversion; hall and encoder channels raw.
module prst_tracker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Motion core
    input wire logic step_pulse,
    input wire logic step_dir,
    input wire logic [7:0] frac_in,
    input wire logic enc_pulse,
    input wire logic enc_dir,
    input wire logic move_start,
    input wire logic [3:0] move_code,
    input wire logic [31:0] move_target,
    input wire logic move_is_shift,
    input wire logic move_done,
    input wire logic move_aborted,
    input wire logic moving,
    input wire logic speed_reached,
    input wire logic backlash_active,
    input wire logic [31:0] speed_in,
    input wire prst_pkg::prst_mode_e motor_mode,
    // Supervisors
    input wire prst_pkg::prst_pwr_e pwr_state,
    input wire prst_pkg::prst_enc_e enc_state,
    input wire prst_pkg::prst_wnd_e wind_a_state,
    input wire prst_pkg::prst_wnd_e wind_b_state,
    input wire logic [2:0] proto_err_evt,
    input wire logic [8:0] critical_flags,
    input wire logic swap_evt,
    input wire logic desync_evt,
    input wire logic pos_correction_on,
    input wire logic desync_corrected,
    input wire logic stage_mem_present,
    // Telemetry
    input wire logic [15:0] supply_ma,
    input wire logic [15:0] supply_10mv,
    input wire logic [15:0] usb_ma,
    input wire logic [15:0] usb_10mv,
    input wire logic [15:0] temp_dc,
    // Digital pins
    input wire logic [10:0] dig_raw,
    input wire logic [10:0] dig_invert,
    input wire logic [4:0] hall_enc_raw,
    // Results
    output logic [31:0] target_pos,
    output logic [31:0] shift_dest_pos,
    output logic [31:0] primary_pos_steps,
    output logic [7:0] primary_pos_fraction,
    output logic [31:0] secondary_pos,
    output logic [3:0] cmd_code_out,
    output logic cmd_running_out,
    output logic cmd_ok_out
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ----------------------------------------
    // State
    // ----------------------------------------
    prst_pkg::prst_state_s st_r;
    prst_pkg::prst_state_s st_nxt;
    logic do_zero;
    logic do_set;
    logic do_query;
    logic do_stop;
    logic [31:0] step_delta;
    logic [31:0] pri_val;
    logic [7:0] pri_frac;
    logic [31:0] sec_val;
    logic [10:0] dig_active;
    logic [31:0] removed;

    assign do_zero = reg_wr && reg_addr == `PRST_A_CTRL && reg_wdata[`PRST_C_ZERO];
    assign do_set = reg_wr && reg_addr == `PRST_A_CTRL && reg_wdata[`PRST_C_SETPOS];
    assign do_query = reg_wr && reg_addr == `PRST_A_CTRL && reg_wdata[`PRST_C_QUERY];
    assign do_stop = reg_wr && reg_addr == `PRST_A_CTRL && reg_wdata[`PRST_C_STOP];
    assign step_delta = step_pulse ? (step_dir ? 32'h0000_0001 : 32'hFFFF_FFFF)
                                   : 32'h0000_0000;
    assign dig_active = dig_raw ^ dig_invert;

    // Primary and secondary views depend on the motor mode
    always_comb begin
        case (motor_mode)
            prst_pkg::PRST_MODE_LEAD_ENC: begin
                pri_val = st_r.enc;
                pri_frac = `PRST_FRAC_ZERO;
                sec_val = st_r.steps;
            end
            prst_pkg::PRST_MODE_FEEDBACK: begin
                pri_val = st_r.enc;
                pri_frac = `PRST_FRAC_ZERO;
                sec_val = st_r.steps;
            end
            prst_pkg::PRST_MODE_DC: begin
                pri_val = st_r.enc;
                pri_frac = `PRST_FRAC_ZERO;
                sec_val = `PRST_POS_ZERO;
            end
            default: begin
                pri_val = st_r.steps;
                pri_frac = st_r.frac;
                sec_val = st_r.enc;
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        removed = `PRST_POS_ZERO;
        // Counters follow the motion core
        st_nxt.steps = st_r.steps + step_delta;
        st_nxt.frac = frac_in;
        if (enc_pulse) begin
            st_nxt.enc = enc_dir ? st_r.enc + 32'h0000_0001 : st_r.enc - 32'h0000_0001;
        end
        if (move_start) begin
            st_nxt.target = move_target;
            st_nxt.shift_dest = move_is_shift ? move_target : st_r.shift_dest;
        end
        // Zero wins over counting in the same cycle to stay coherent
        if (do_zero) begin
            removed = st_r.steps;
            st_nxt.steps = `PRST_POS_ZERO;
            st_nxt.frac = `PRST_FRAC_ZERO;
            st_nxt.enc = `PRST_POS_ZERO;
            st_nxt.target = st_r.target - removed;
            st_nxt.shift_dest = st_r.shift_dest - removed;
        end else if (do_set) begin
            if (!reg_wdata[`PRST_C_IGN_MOTOR]) begin
                removed = st_r.steps - st_r.set_steps;
                st_nxt.steps = st_r.set_steps;
                st_nxt.frac = st_r.set_frac;
                st_nxt.target = st_r.target - removed;
                st_nxt.shift_dest = st_r.shift_dest - removed;
            end
            if (!reg_wdata[`PRST_C_IGN_ENC]) begin
                st_nxt.enc = st_r.set_enc;
            end
        end
        // Command status
        if (move_start) begin
            st_nxt.cmd_code = move_code;
            st_nxt.cmd_running = 1'b1;
            st_nxt.cmd_ok = 1'b1;
        end else if (st_r.cmd_running && (move_done || move_aborted)) begin
            st_nxt.cmd_running = 1'b0;
            st_nxt.cmd_ok = !move_aborted;
        end
        // Sticky flags; a new event beats the clear
        st_nxt.proto_err = (do_stop ? 3'b000 : st_r.proto_err) | proto_err_evt;
        st_nxt.swap_err = (do_stop ? 1'b0 : st_r.swap_err) | swap_evt;
        st_nxt.desync_err = ((pos_correction_on && desync_corrected) ? 1'b0 : st_r.desync_err)
                            | desync_evt;
        // Register writes for set-position values
        if (reg_wr && reg_addr == `PRST_A_SET_STEPS) begin
            st_nxt.set_steps = reg_wdata;
        end
        if (reg_wr && reg_addr == `PRST_A_SET_FRAC) begin
            st_nxt.set_frac = reg_wdata[7:0];
        end
        if (reg_wr && reg_addr == `PRST_A_SET_SEC) begin
            st_nxt.set_enc = reg_wdata;
        end
        // One-cycle capture keeps every field of a reply from the same update
        if (do_query) begin
            st_nxt.snap_pos = pri_val;
            st_nxt.snap_frac = pri_frac;
            st_nxt.snap_sec = sec_val;
            st_nxt.snap_speed = speed_in;
            st_nxt.snap_state = {14'h0000, wind_b_state, wind_a_state, enc_state, pwr_state,
                                 st_r.cmd_ok, st_r.cmd_running, st_r.cmd_code,
                                 backlash_active, speed_reached, moving};
            st_nxt.snap_flags = {16'h0000, `PRST_EXT_SUPPLY, stage_mem_present,
                                 st_r.desync_err, st_r.swap_err, critical_flags,
                                 st_r.proto_err};
            st_nxt.snap_tel0 = {supply_10mv, supply_ma};
            st_nxt.snap_tel1 = {usb_10mv, usb_ma};
            st_nxt.snap_tel2 = {16'h0000, temp_dc};
            st_nxt.snap_dig = {16'h0000, hall_enc_raw, dig_active};
        end
        // Read port: data in the cycle after the strobe, unmapped reads zero
        st_nxt.rdata = `PRST_POS_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                `PRST_A_SET_STEPS: st_nxt.rdata = st_r.set_steps;
                `PRST_A_SET_FRAC: st_nxt.rdata = {24'h00_0000, st_r.set_frac};
                `PRST_A_SET_SEC: st_nxt.rdata = st_r.set_enc;
                `PRST_A_STAT_STEPS: st_nxt.rdata = st_r.snap_pos;
                `PRST_A_STAT_FRAC: st_nxt.rdata = {24'h00_0000, st_r.snap_frac};
                `PRST_A_STAT_SEC: st_nxt.rdata = st_r.snap_sec;
                `PRST_A_STAT_SPEED: st_nxt.rdata = st_r.snap_speed;
                `PRST_A_STAT_STATE: st_nxt.rdata = st_r.snap_state;
                `PRST_A_STAT_FLAGS: st_nxt.rdata = st_r.snap_flags;
                `PRST_A_STAT_TEL0: st_nxt.rdata = st_r.snap_tel0;
                `PRST_A_STAT_TEL1: st_nxt.rdata = st_r.snap_tel1;
                `PRST_A_STAT_TEL2: st_nxt.rdata = st_r.snap_tel2;
                `PRST_A_STAT_DIG: st_nxt.rdata = st_r.snap_dig;
                `PRST_A_TARGET: st_nxt.rdata = st_r.target;
                default: st_nxt.rdata = `PRST_POS_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.cmd_code <= `PRST_CMD_UNKNOWN;
            st_r.cmd_ok <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign target_pos = st_r.target;
    assign shift_dest_pos = st_r.shift_dest;
    assign primary_pos_steps = st_r.steps;
    assign primary_pos_fraction = st_r.frac;
    assign secondary_pos = st_r.enc;
    assign cmd_code_out = st_r.cmd_code;
    assign cmd_running_out = st_r.cmd_running;
    assign cmd_ok_out = st_r.cmd_ok;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence zero_req;
        do_zero;
    endsequence

    chk_zero_clears_all: assert property (@(posedge core_clk) disable iff (!rst_n)
        zero_req |=> (st_r.steps == 32'h0 && st_r.enc == 32'h0))
        else $error("zero left a counter set");
    chk_zero_frac_same: assert property (@(posedge core_clk) disable iff (!rst_n)
        zero_req |=> st_r.frac == 8'h00 && st_r.steps == 32'h0)
        else $error("zero fraction not in same update");
    chk_zero_target_shift: assert property (@(posedge core_clk) disable iff (!rst_n)
        (zero_req and !move_start) |=> st_r.target == $past(st_r.target) - $past(st_r.steps))
        else $error("target not shifted on zero");
    chk_zero_shift_dest: assert property (@(posedge core_clk) disable iff (!rst_n)
        (zero_req and !move_start) |=>
            st_r.shift_dest == $past(st_r.shift_dest) - $past(st_r.steps))
        else $error("shift destination moved");
    chk_setpos_ignore: assert property (@(posedge core_clk) disable iff (!rst_n)
        do_set && !do_zero && reg_wdata[`PRST_C_IGN_ENC] && !enc_pulse |=>
            st_r.enc == $past(st_r.enc))
        else $error("ignored encoder changed");
    chk_cmd_abort_fail: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_r.cmd_running && move_aborted && !move_start |=> !st_r.cmd_ok && !st_r.cmd_running)
        else $error("aborted command not failed");
    chk_proto_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_r.proto_err[0] && !do_stop |=> st_r.proto_err[0])
        else $error("protocol flag lost");
    chk_ext_supply_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        do_query |=> st_r.snap_flags[15])
        else $error("external supply flag clear");
    chk_query_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        do_query ##4 (reg_rd && reg_addr == `PRST_A_STAT_STEPS) |=>
            reg_rdata == $past(pri_val, 5))
        else $error("snapshot read mismatch");
endmodule

// ===== tb/prst_host_model.sv
// Host side model: issues register port commands to the tracker.
// Assumes one clock; strobes change by non-blocking assignment after a rising edge.
`timescale 1ns/1ns
module prst_host_model (
    // Clock
    input wire logic core_clk,
    // Register port
    output logic [3:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Strobe is released one edge later, so a following call never collides with it
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule

// ===== tb/prst_tracker_bench.sv
// Self-checking bench for the position counters and status snapshot.
// Assumes the host model drives the register port; the bench plays the motion core.
`timescale 1ns/1ns
`include "prst_consts.svh"
module prst_tracker_bench;
    logic core_clk;
    logic reset_n;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd;
    logic step_pulse, step_dir, enc_pulse, enc_dir, move_start, move_is_shift;
    logic move_done, move_aborted, moving, speed_reached, backlash_active;
    logic swap_evt, desync_evt, pos_correction_on, desync_corrected, stage_mem_present;
    logic [7:0] frac_in, primary_pos_fraction;
    logic [3:0] move_code, cmd_code_out;
    logic [31:0] move_target, speed_in, target_pos, shift_dest_pos;
    logic [31:0] primary_pos_steps, secondary_pos;
    prst_pkg::prst_mode_e motor_mode;
    prst_pkg::prst_pwr_e pwr_state;
    prst_pkg::prst_enc_e enc_state;
    prst_pkg::prst_wnd_e wind_a_state, wind_b_state;
    logic [2:0] proto_err_evt;
    logic [8:0] critical_flags;
    logic [15:0] supply_ma, supply_10mv, usb_ma, usb_10mv, temp_dc;
    logic [10:0] dig_raw, dig_invert;
    logic [4:0] hall_enc_raw;
    logic cmd_running_out, cmd_ok_out;
    int miscompares;
    int compares;

    prst_tracker i_prst_tracker (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .step_pulse, .step_dir, .frac_in, .enc_pulse, .enc_dir,
        .move_start, .move_code, .move_target, .move_is_shift, .move_done, .move_aborted,
        .moving, .speed_reached, .backlash_active, .speed_in, .motor_mode, .pwr_state,
        .enc_state, .wind_a_state, .wind_b_state, .proto_err_evt, .critical_flags,
        .swap_evt, .desync_evt, .pos_correction_on, .desync_corrected, .stage_mem_present,
        .supply_ma, .supply_10mv, .usb_ma, .usb_10mv, .temp_dc, .dig_raw, .dig_invert,
        .hall_enc_raw, .target_pos, .shift_dest_pos, .primary_pos_steps,
        .primary_pos_fraction, .secondary_pos, .cmd_code_out, .cmd_running_out,
        .cmd_ok_out);
    prst_host_model i_prst_host_model (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic ctrl(input logic [31:0] bits);
        i_prst_host_model.wr(`PRST_A_CTRL, bits);
        settle();
    endtask

    task automatic snap_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        i_prst_host_model.rd(a, d);
        check(what, d, exp);
    endtask

    task automatic start_move(input logic [3:0] code, input logic [31:0] tgt);
        @(posedge core_clk);
        move_start <= 1'b1;
        move_code <= code;
        move_target <= tgt;
        @(posedge core_clk);
        move_start <= 1'b0;
        settle();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        check("cmd code", cmd_code_out, `PRST_CMD_UNKNOWN);
        check("cmd ok", cmd_ok_out, 1);
        check("cmd running", cmd_running_out, 0);
        snap_chk("unmapped read", 4'hF, 32'h0000_0000);
        settle();
        check("idle rdata", reg_rdata, 32'h0000_0000);
        $display("test_reset done");
    endtask

    task automatic test_zero();
        move_is_shift <= 1'b1;
        start_move(4'h1, 32'h0000_03E8);
        move_is_shift <= 1'b0;
        repeat (5) begin
            @(posedge core_clk);
            step_pulse <= 1'b1;
            enc_pulse <= 1'b1;
            @(posedge core_clk);
            step_pulse <= 1'b0;
            enc_pulse <= 1'b0;
        end
        settle();
        check("steps moved", primary_pos_steps, 32'h0000_0005);
        ctrl(32'h0000_0001);
        check("steps zeroed", primary_pos_steps, `PRST_POS_ZERO);
        check("encoder zeroed", secondary_pos, `PRST_POS_ZERO);
        check("target shifted", target_pos, 32'h0000_03E3);
        check("move kept", cmd_running_out, 1);
        check("shift dest", shift_dest_pos, 32'h0000_03E3);
        $display("test_zero done");
    endtask

    task automatic test_setpos();
        i_prst_host_model.wr(`PRST_A_SET_STEPS, 32'h0000_0064);
        i_prst_host_model.wr(`PRST_A_SET_SEC, 32'h0000_0040);
        ctrl(32'h0000_0002);
        check("set steps", primary_pos_steps, 32'h0000_0064);
        check("set encoder", secondary_pos, 32'h0000_0040);
        check("set target", target_pos, 32'h0000_0447);
        i_prst_host_model.wr(`PRST_A_SET_STEPS, 32'h0000_0007);
        i_prst_host_model.wr(`PRST_A_SET_SEC, 32'h0000_0009);
        ctrl(32'h0000_000A);
        check("ign enc steps", primary_pos_steps, 32'h0000_0007);
        check("ign enc encoder", secondary_pos, 32'h0000_0040);
        check("ign enc target", target_pos, 32'h0000_03EA);
        ctrl(32'h0000_0006);
        check("ign mot steps", primary_pos_steps, 32'h0000_0007);
        check("ign mot encoder", secondary_pos, 32'h0000_0009);
        check("ign mot target", target_pos, 32'h0000_03EA);
        $display("test_setpos done");
    endtask

    task automatic test_command();
        @(posedge core_clk);
        move_done <= 1'b1;
        @(posedge core_clk);
        move_done <= 1'b0;
        settle();
        check("done running", cmd_running_out, 0);
        check("done ok", cmd_ok_out, 1);
        start_move(4'h5, 32'h0000_0010);
        check("new code", cmd_code_out, 4'h5);
        check("new running", cmd_running_out, 1);
        @(posedge core_clk);
        move_aborted <= 1'b1;
        @(posedge core_clk);
        move_aborted <= 1'b0;
        settle();
        check("abort running", cmd_running_out, 0);
        check("abort ok", cmd_ok_out, 0);
        $display("test_command done");
    endtask

    task automatic test_snapshot();
        logic [31:0] exp;
        for (int k = 0; k < 5; k++) begin
            @(posedge core_clk);
            pwr_state <= prst_pkg::prst_pwr_e'(k[1:0]);
            enc_state <= prst_pkg::prst_enc_e'(k[2:0]);
            wind_a_state <= prst_pkg::prst_wnd_e'(k[1:0]);
            wind_b_state <= prst_pkg::prst_wnd_e'(~k[1:0]);
            moving <= k[0];
            speed_reached <= k[1];
            backlash_active <= ~k[0];
            speed_in <= 32'h0001_0000 + k;
            exp = {14'h0, ~k[1:0], k[1:0], k[2:0], k[1:0], 2'b00, 4'h5, ~k[0], k[1], k[0]};
            ctrl(32'h0000_0010);
            // Inputs move on after the query; the reply must not follow them
            speed_in <= 32'hFFFF_0000;
            moving <= ~k[0];
            settle();
            snap_chk("state word", `PRST_A_STAT_STATE, exp);
            snap_chk("speed", `PRST_A_STAT_SPEED, 32'h0001_0000 + k);
        end
        snap_chk("tel0", `PRST_A_STAT_TEL0, 32'h5678_1234);
        snap_chk("tel1", `PRST_A_STAT_TEL1, 32'hDEF0_9ABC);
        snap_chk("tel2", `PRST_A_STAT_TEL2, 32'h0000_0123);
        snap_chk("digital", `PRST_A_STAT_DIG, {16'h0000, 5'h15, 11'h555});
        frac_in <= 8'h33;
        motor_mode <= prst_pkg::PRST_MODE_LEAD_ENC;
        ctrl(32'h0000_0010);
        snap_chk("lead steps", `PRST_A_STAT_STEPS, 32'h0000_0009);
        snap_chk("lead frac", `PRST_A_STAT_FRAC, 32'h0000_0000);
        motor_mode <= prst_pkg::PRST_MODE_OPEN;
        ctrl(32'h0000_0010);
        snap_chk("open steps", `PRST_A_STAT_STEPS, 32'h0000_0007);
        snap_chk("open sec", `PRST_A_STAT_SEC, 32'h0000_0009);
        motor_mode <= prst_pkg::PRST_MODE_FEEDBACK;
        ctrl(32'h0000_0010);
        snap_chk("feedback sec", `PRST_A_STAT_SEC, 32'h0000_0007);
        motor_mode <= prst_pkg::PRST_MODE_DC;
        ctrl(32'h0000_0010);
        snap_chk("dc sec", `PRST_A_STAT_SEC, 32'h0000_0000);
        $display("test_snapshot done");
    endtask

    task automatic test_flags();
        @(posedge core_clk);
        proto_err_evt <= 3'b101;
        swap_evt <= 1'b1;
        desync_evt <= 1'b1;
        critical_flags <= 9'h1AA;
        @(posedge core_clk);
        proto_err_evt <= 3'b000;
        swap_evt <= 1'b0;
        desync_evt <= 1'b0;
        ctrl(32'h0000_0010);
        snap_chk("flags set", `PRST_A_STAT_FLAGS, 32'h0000_FD55);
        critical_flags <= 9'h000;
        stage_mem_present <= 1'b0;
        ctrl(32'h0000_0020);
        ctrl(32'h0000_0010);
        snap_chk("flags stop", `PRST_A_STAT_FLAGS, 32'h0000_A000);
        pos_correction_on <= 1'b1;
        desync_corrected <= 1'b1;
        settle();
        ctrl(32'h0000_0010);
        snap_chk("flags corr", `PRST_A_STAT_FLAGS, 32'h0000_8000);
        $display("test_flags done");
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        close_out();
    end

    initial begin
        miscompares = 0;
        compares = 0;
        reset_n = 1'b0;
        {step_pulse, enc_pulse, move_start, move_is_shift, move_done, move_aborted} = '0;
        {moving, speed_reached, backlash_active, swap_evt, desync_evt} = '0;
        {pos_correction_on, desync_corrected} = '0;
        step_dir = 1'b1;
        enc_dir = 1'b1;
        stage_mem_present = 1'b1;
        frac_in = 8'h00;
        move_code = 4'h0;
        move_target = 32'h0000_0000;
        speed_in = 32'h0000_0000;
        motor_mode = prst_pkg::PRST_MODE_OPEN;
        pwr_state = prst_pkg::PRST_PWR_OFF;
        enc_state = prst_pkg::PRST_ENC_ABSENT;
        wind_a_state = prst_pkg::PRST_WND_OPEN;
        wind_b_state = prst_pkg::PRST_WND_OPEN;
        proto_err_evt = 3'b000;
        critical_flags = 9'h000;
        {supply_ma, supply_10mv, usb_ma, usb_10mv} = {16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
        temp_dc = 16'h0123;
        dig_raw = 11'h5A5;
        dig_invert = 11'h0F0;
        hall_enc_raw = 5'h15;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        test_reset();
        test_zero();
        test_setpos();
        test_command();
        test_snapshot();
        test_flags();
        close_out();
    end
endmodule
